// ### i2c_regslave.sv
// I2C slave giving byte access to a 256-register space
// Summary of operation
// - Straps set low two address bits
// - Standard and fast speeds only
// - Accept 7-bit and 10-bit addressing
// - Ignore bus until a start
// - Stop ends transaction, returns idle
// - Ninth bit carries receiver acknowledge
// - Sample on clock rise, change when low
// - Ack own address, else stay off bus
// - Direction bit one reads, zero writes
// - Eight-bit pointer, 256 byte registers
// - Sequential writes advance the pointer
// - Reads follow consecutive addresses, wrapping
// - Master nack ends read, slave idles
// - Write pointer wraps past last register
// - Ack general call, take command byte
// - Command 0x06: soft reset and latch
// - Command 0x04: latch straps only
// - Other command bytes are ignored
// - Three power states, serial always usable
`timescale 1ns/1ps
module i2c_regslave (
	input  wire logic                     clk_sys_i,
	input  wire logic                     rst_n_i,
	input  wire logic                     scl_i,
	input  wire logic                     sda_i,
	input  wire logic [1:0]               strap_i,
	input  wire i2c_rs_pkg::power_state_t power_state_i,
	output logic                          sda_o,
	output logic                          sda_oe_o,
	output logic                          soft_reset_o,
	output logic [6:0]                    slave_addr_o,
	output logic                          busy_o,
	output logic                          pwm_en_o,
	output logic                          sense_slow_o,
	output logic                          prox_en_o
);
	import i2c_rs_pkg::*;

	// ************************************************************
	// Declarations
	// ************************************************************
	slave_state_t state_q;      // Protocol state
	byte_kind_t   kind_q;       // Meaning of byte being received
	logic [3:0]   cnt_q;        // Bit counter
	logic [7:0]   sh_q;         // Shift register
	logic         sda_oe_q;     // Pull data low
	logic         sda_q;        // Driven level, always low
	logic         read_q;       // Next phase is a read
	logic [7:0]   ptr_q;        // Register pointer
	logic         ten_sel_q;    // Selected by 10-bit write phase
	logic [1:0]   strap_q;      // Latched strap bits
	logic [2:0]   settle_q;     // Strap settle counter, one past the pipeline
	logic         strap_vld_q;  // First capture done
	logic         soft_rst_q;   // Soft reset pulse
	logic [6:0]   addr_q;       // Own 7-bit address
	logic         busy_q;       // Transaction in progress
	logic         pwm_q;        // PWM allowed
	logic         slow_q;       // Sensing in slow mode
	logic         prox_q;       // Proximity sensing allowed
	logic         sda_lvl;      // Filtered data level
	logic         scl_rise;     // Clock rise pulse
	logic         scl_fall;     // Clock fall pulse
	logic         start;        // Start or repeated start
	logic         stop;         // Stop
	logic [1:0]   strap_sync;   // Filtered straps
	logic [7:0]   rd_data;      // Byte at pointer
	logic         dec_fire;     // Byte complete, ack slot begins
	logic         dec_ack;      // Acknowledge this byte
	logic         dec_read;     // Move to transmit after ack
	byte_kind_t   dec_kind;     // Kind of next byte
	logic         dec_ptr_load; // Byte is pointer
	logic         dec_wr;       // Byte is data
	logic         dec_gc_rst;   // Soft reset command
	logic         dec_gc_latch; // Strap latch command
	logic         dec_ten_set;  // 10-bit address matched
	logic         wr_en;        // Register write strobe
	logic         bus_evt;      // Any event that may move data pin

	// ************************************************************
	// Pin sensing and storage
	// ************************************************************
	// Oversampling suits both speeds
	i2c_bus_sense u_sense (
		.clk_sys_i  (clk_sys_i),
		.rst_n_i    (rst_n_i),
		.scl_i      (scl_i),
		.sda_i      (sda_i),
		.strap_i    (strap_i),
		.sda_lvl_o  (sda_lvl),
		.scl_rise_o (scl_rise),
		.scl_fall_o (scl_fall),
		.start_o    (start),
		.stop_o     (stop),
		.strap_o    (strap_sync)
	);

	reg_bank u_bank (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.clear_i   (soft_rst_q),
		.wr_en_i   (wr_en),
		.wr_addr_i (ptr_q),
		.wr_data_i (sh_q),
		.rd_addr_i (ptr_q),
		.rd_data_o (rd_data)
	);

	assign dec_fire = (state_q == ST_RX) && scl_fall && (cnt_q == BIT_LAST) && !start && !stop;
	// Write lands as ack is driven
	assign wr_en    = dec_fire && dec_ack && dec_wr;
	assign bus_evt  = scl_fall || start || stop;

	// ************************************************************
	// Byte decoder
	// ************************************************************
	always_comb begin
		dec_ack      = 1'b0;
		dec_read     = 1'b0;
		dec_kind     = K_DATA;
		dec_ptr_load = 1'b0;
		dec_wr       = 1'b0;
		dec_gc_rst   = 1'b0;
		dec_gc_latch = 1'b0;
		dec_ten_set  = 1'b0;
		unique case (kind_q)
			K_ADDR: begin
				if (sh_q[7:1] == addr_q) begin
					dec_ack  = 1'b1;
					dec_read = sh_q[0];
					dec_kind = K_REGPTR;
				end else if (sh_q == GC_ADDR_BYTE) begin
					dec_ack  = 1'b1;
					dec_kind = K_GC;
				end else if (sh_q[7:3] == TEN_BIT_PREFIX && sh_q[2:1] == ADDR10_HIGH) begin
					if (!sh_q[0]) begin
						dec_ack  = 1'b1;
						dec_kind = K_ADDR10;
					end else if (ten_sel_q) begin
						// Read needs earlier full match
						dec_ack  = 1'b1;
						dec_read = 1'b1;
					end
				end
			end
			K_ADDR10: begin
				if (sh_q == {1'b0, addr_q}) begin
					dec_ack     = 1'b1;
					dec_ten_set = 1'b1;
					dec_kind    = K_REGPTR;
				end
			end
			K_REGPTR: begin
				dec_ack      = 1'b1;
				dec_ptr_load = 1'b1;
			end
			K_DATA: begin
				dec_ack = 1'b1;
				dec_wr  = 1'b1;
			end
			K_GC: begin
				dec_kind = K_GC_DONE;
				if (sh_q == GC_RESET_LATCH) begin
					dec_ack      = 1'b1;
					dec_gc_rst   = 1'b1;
					dec_gc_latch = 1'b1;
				end else if (sh_q == GC_LATCH_ONLY) begin
					dec_ack      = 1'b1;
					dec_gc_latch = 1'b1;
				end
			end
			K_GC_DONE: begin
				// Extra bytes after a command get no ack
				dec_ack = 1'b0;
			end
		endcase
	end

	// ************************************************************
	// Protocol state machine
	// ************************************************************
	// Stop beats start beats clock edges
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			state_q  <= ST_IDLE;
			kind_q   <= K_ADDR;
			cnt_q    <= 4'h0;
			sh_q     <= 8'h00;
			sda_oe_q <= 1'b0;
			read_q   <= 1'b0;
		end else if (stop) begin
			state_q  <= ST_IDLE;
			sda_oe_q <= 1'b0;
		end else if (start) begin
			state_q  <= ST_RX;
			kind_q   <= K_ADDR;
			cnt_q    <= 4'h0;
			sda_oe_q <= 1'b0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					// Wait for a start
					cnt_q <= cnt_q;
				end
				ST_RX: begin
					if (scl_rise && cnt_q != BIT_LAST) begin
						sh_q  <= {sh_q[6:0], sda_lvl};
						cnt_q <= cnt_q + 4'h1;
					end else if (dec_fire) begin
						if (dec_ack) begin
							sda_oe_q <= 1'b1;
							state_q  <= ST_RX_ACK;
							kind_q   <= dec_kind;
							read_q   <= dec_read;
						end else begin
							// Off the bus until next start
							state_q <= ST_IDLE;
						end
					end
				end
				ST_RX_ACK: begin
					if (scl_fall) begin
						cnt_q <= 4'h0;
						if (read_q) begin
							state_q  <= ST_TX;
							sh_q     <= rd_data;
							sda_oe_q <= ~rd_data[7];
						end else begin
							state_q  <= ST_RX;
							sda_oe_q <= 1'b0;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (cnt_q == TX_LAST) begin
							sda_oe_q <= 1'b0;
							state_q  <= ST_TX_ACK;
						end else begin
							cnt_q    <= cnt_q + 4'h1;
							sh_q     <= {sh_q[6:0], 1'b0};
							sda_oe_q <= ~sh_q[6];
						end
					end
				end
				ST_TX_ACK: begin
					if (scl_rise) begin
						if (sda_lvl) begin
							state_q <= ST_IDLE;
						end
					end else if (scl_fall) begin
						cnt_q    <= 4'h0;
						state_q  <= ST_TX;
						sh_q     <= rd_data;
						sda_oe_q <= ~rd_data[7];
					end
				end
			endcase
		end
	end

	// ************************************************************
	// Register pointer
	// ************************************************************
	// Eight-bit arithmetic gives the wrap for free
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || soft_rst_q) begin
			ptr_q <= PTR_RESET;
		end else if (dec_fire && dec_ptr_load) begin
			ptr_q <= sh_q;
		end else if (wr_en) begin
			ptr_q <= ptr_q + 8'h01;
		end else if (state_q == ST_TX_ACK && scl_rise && !start && !stop) begin
			ptr_q <= ptr_q + 8'h01;
		end
	end

	// ************************************************************
	// 10-bit selection and general call
	// ************************************************************
	// Selection survives repeated start, not stop
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || stop) begin
			ten_sel_q <= 1'b0;
		end else if (dec_fire && dec_ten_set) begin
			ten_sel_q <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			soft_rst_q <= 1'b0;
		end else begin
			soft_rst_q <= dec_fire && dec_gc_rst;
		end
	end

	// Straps caught after release, then on command
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			strap_q     <= STRAP_RESET;
			settle_q    <= 3'h0;
			strap_vld_q <= 1'b0;
		end else if (!strap_vld_q) begin
			settle_q <= settle_q + 3'h1;
			// Filtered straps are valid only one edge after the pipe fills
			if (settle_q == {1'b0, STRAP_SETTLE} + 3'h1) begin
				strap_q     <= strap_sync;
				strap_vld_q <= 1'b1;
			end
		end else if (dec_fire && dec_gc_latch) begin
			strap_q <= strap_sync;
		end
	end

	// ************************************************************
	// Status and power outputs
	// ************************************************************
	// Serial logic ignores power state
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			addr_q <= ADDR7_BASE;
			busy_q <= 1'b0;
			pwm_q  <= 1'b0;
			slow_q <= 1'b0;
			prox_q <= 1'b0;
			sda_q  <= 1'b0;
		end else begin
			addr_q <= {ADDR7_BASE[6:2], strap_q};
			busy_q <= (state_q != ST_IDLE);
			pwm_q  <= (power_state_i != PWR_HIBERNATE);
			slow_q <= (power_state_i == PWR_SLEEP);
			prox_q <= (power_state_i == PWR_ACTIVE);
			sda_q  <= 1'b0;
		end
	end

	assign sda_o        = sda_q;
	assign sda_oe_o     = sda_oe_q;
	assign soft_reset_o = soft_rst_q;
	assign slave_addr_o = addr_q;
	assign busy_o       = busy_q;
	assign pwm_en_o     = pwm_q;
	assign sense_slow_o = slow_q;
	assign prox_en_o    = prox_q;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	property p_addr_base;
		slave_addr_o[6:2] == ADDR7_BASE[6:2];
	endproperty
	a_addr_base: assert property (p_addr_base) else $error("address base wrong");
	property p_idle_quiet;
		state_q == ST_IDLE |-> !sda_oe_o;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("drive while idle");
	property p_stop_idle;
		stop |=> (state_q == ST_IDLE) && !sda_oe_o;
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("stop not honoured");
	property p_tx_release;
		state_q == ST_TX_ACK |-> !sda_oe_o;
	endproperty
	a_tx_release: assert property (p_tx_release) else $error("data held in ack slot");
	property p_edge_time;
		$changed(sda_oe_o) |-> $past(bus_evt);
	endproperty
	a_edge_time: assert property (p_edge_time) else $error("data moved off clock low");
	property p_addr_ack;
		dec_fire && kind_q == K_ADDR && sh_q[7:1] == slave_addr_o |=> sda_oe_o && state_q == ST_RX_ACK;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("own address not acked");
	property p_miss_off;
		dec_fire && !dec_ack |=> ((state_q == ST_IDLE) && !sda_oe_o) [*2];
	endproperty
	a_miss_off: assert property (p_miss_off) else $error("responded to other address");
	property p_dir;
		dec_fire && kind_q == K_ADDR && sh_q[7:1] == slave_addr_o |=> read_q == $past(sh_q[0]);
	endproperty
	a_dir: assert property (p_dir) else $error("direction bit misread");
	property p_wr_step;
		wr_en |=> ptr_q == $past(ptr_q) + 8'h01;
	endproperty
	a_wr_step: assert property (p_wr_step) else $error("write pointer not advanced");
	property p_commit_ack;
		wr_en |=> sda_oe_o && state_q == ST_RX_ACK;
	endproperty
	a_commit_ack: assert property (p_commit_ack) else $error("write not in ack slot");
	property p_nack_end;
		state_q == ST_TX_ACK && scl_rise && sda_lvl && !start && !stop |=> state_q == ST_IDLE;
	endproperty
	a_nack_end: assert property (p_nack_end) else $error("read kept after nack");
	property p_soft_rst;
		dec_fire && dec_gc_rst |=> soft_reset_o ##1 !soft_reset_o && ptr_q == PTR_RESET;
	endproperty
	a_soft_rst: assert property (p_soft_rst) else $error("soft reset missing");
	property p_latch_only;
		dec_fire && kind_q == K_GC && sh_q == GC_LATCH_ONLY |=> !soft_reset_o && sda_oe_o;
	endproperty
	a_latch_only: assert property (p_latch_only) else $error("latch command misbehaved");

	c_write: cover property (wr_en);
	c_read_wrap: cover property (state_q == ST_TX_ACK && scl_rise && ptr_q == 8'hff);
	c_gc_reset: cover property (dec_fire && dec_gc_rst);
	c_ten_bit: cover property (dec_fire && dec_ten_set);

endmodule : i2c_regslave

// ### i2c_rs_pkg.sv
// Shared constants and types for the register access I2C slave
package i2c_rs_pkg;

	// ************************************************************
	// Addressing
	// ************************************************************
	localparam logic [6:0] ADDR7_BASE     = 7'h58; // Low two bits come from straps
	localparam logic [1:0] STRAP_RESET    = 2'h0;  // Strap copy before first capture
	localparam logic [1:0] STRAP_SETTLE   = 2'h3;  // Cycles for strap pipeline to fill
	localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e; // First byte marker of 10-bit address
	localparam logic [1:0] ADDR10_HIGH    = 2'h0;  // Upper two bits of own 10-bit address
	localparam logic [7:0] GC_ADDR_BYTE   = 8'h00; // General call address with write
	localparam logic [7:0] GC_RESET_LATCH = 8'h06; // Soft reset plus strap latch
	localparam logic [7:0] GC_LATCH_ONLY  = 8'h04; // Strap latch only

	// ************************************************************
	// Register space and bit counting
	// ************************************************************
	localparam int         REG_COUNT = 256;   // Number of byte registers
	localparam logic [7:0] REG_RESET = 8'h00; // Register value after reset
	localparam logic [7:0] PTR_RESET = 8'h00; // Pointer value after reset
	localparam logic [3:0] BIT_LAST  = 4'h8;  // Bits received before the ack slot
	localparam logic [3:0] TX_LAST   = 4'h7;  // Index of last bit sent

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [1:0] {PWR_HIBERNATE, PWR_SLEEP, PWR_ACTIVE} power_state_t;
	typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK} slave_state_t;
	typedef enum logic [2:0] {K_ADDR, K_ADDR10, K_REGPTR, K_DATA, K_GC, K_GC_DONE} byte_kind_t;

endpackage : i2c_rs_pkg

// ### i2c_bus_sense.sv
// Pin synchroniser and start, stop and clock edge detector
`timescale 1ns/1ps
module i2c_bus_sense (
	input  wire logic       clk_sys_i,
	input  wire logic       rst_n_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	input  wire logic [1:0] strap_i,
	output logic            sda_lvl_o,
	output logic            scl_rise_o,
	output logic            scl_fall_o,
	output logic            start_o,
	output logic            stop_o,
	output logic [1:0]      strap_o
);
	import i2c_rs_pkg::*;

	// Level moves only when stages two and three agree
	function automatic logic agree(input logic s2, input logic s3, input logic lvl);
		agree = (s2 == s3) ? s3 : lvl;
	endfunction : agree

	logic [2:0] scl_sh_q;    // Stage 0 is the first flop
	logic [2:0] sda_sh_q;    // Stage 0 is the first flop
	logic [2:0] st0_sh_q;    // Strap bit 0 stages
	logic [2:0] st1_sh_q;    // Strap bit 1 stages
	logic       scl_lvl_q;   // Filtered clock level
	logic       sda_lvl_q;   // Filtered data level
	logic       scl_n;       // Next clock level
	logic       sda_n;       // Next data level
	logic       rise_q;      // Clock rise pulse
	logic       fall_q;      // Clock fall pulse
	logic       start_q;     // Start pulse
	logic       stop_q;      // Stop pulse
	logic [1:0] strap_q;     // Filtered straps

	assign scl_n = agree(scl_sh_q[1], scl_sh_q[2], scl_lvl_q);
	assign sda_n = agree(sda_sh_q[1], sda_sh_q[2], sda_lvl_q);

	// ************************************************************
	// Three-flop pipelines and filtered levels
	// ************************************************************
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			scl_sh_q  <= 3'h7;
			sda_sh_q  <= 3'h7;
			st0_sh_q  <= 3'h0;
			st1_sh_q  <= 3'h0;
			scl_lvl_q <= 1'b1;
			sda_lvl_q <= 1'b1;
			strap_q   <= STRAP_RESET;
		end else begin
			scl_sh_q  <= {scl_sh_q[1:0], scl_i};
			sda_sh_q  <= {sda_sh_q[1:0], sda_i};
			st0_sh_q  <= {st0_sh_q[1:0], strap_i[0]};
			st1_sh_q  <= {st1_sh_q[1:0], strap_i[1]};
			scl_lvl_q <= scl_n;
			sda_lvl_q <= sda_n;
			strap_q   <= {agree(st1_sh_q[1], st1_sh_q[2], strap_q[1]),
				agree(st0_sh_q[1], st0_sh_q[2], strap_q[0])};
		end
	end

	// ************************************************************
	// Bus events
	// ************************************************************
	// Start and stop need clock high before and after the data edge
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			rise_q  <= 1'b0;
			fall_q  <= 1'b0;
			start_q <= 1'b0;
			stop_q  <= 1'b0;
		end else begin
			rise_q  <= !scl_lvl_q && scl_n;
			fall_q  <= scl_lvl_q && !scl_n;
			start_q <= scl_lvl_q && scl_n && sda_lvl_q && !sda_n;
			stop_q  <= scl_lvl_q && scl_n && !sda_lvl_q && sda_n;
		end
	end

	assign sda_lvl_o  = sda_lvl_q;
	assign scl_rise_o = rise_q;
	assign scl_fall_o = fall_q;
	assign start_o    = start_q;
	assign stop_o     = stop_q;
	assign strap_o    = strap_q;

endmodule : i2c_bus_sense

// ### reg_bank.sv
// Byte register space held in flip-flops
`timescale 1ns/1ps
module reg_bank (
	input  wire logic       clk_sys_i,
	input  wire logic       rst_n_i,
	input  wire logic       clear_i,
	input  wire logic       wr_en_i,
	input  wire logic [7:0] wr_addr_i,
	input  wire logic [7:0] wr_data_i,
	input  wire logic [7:0] rd_addr_i,
	output logic      [7:0] rd_data_o
);
	import i2c_rs_pkg::*;

	logic [7:0] mem_q [REG_COUNT]; // One byte per register

	// ************************************************************
	// Storage
	// ************************************************************
	// Soft reset clears like a hard reset
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || clear_i) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				mem_q[i] <= REG_RESET;
			end
		end else if (wr_en_i) begin
			mem_q[wr_addr_i] <= wr_data_i;
		end
	end

	assign rd_data_o = mem_q[rd_addr_i];

endmodule : reg_bank

// ### i2c_master_model.sv
// Bit-level I2C bus master model for the register slave
`timescale 1ns/1ps
module i2c_master_model (
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_o
);
	// Quarter of the 160 ns link clock period
	localparam time Q = 40;
	// Idle bus, both lines released high
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic start;
		sda_o = 1'b1;
		#(2*Q) scl_o = 1'b1;
		#(2*Q) sda_o = 1'b0;
		#(2*Q) scl_o = 1'b0;
		#Q;
	endtask : start
	task automatic stop;
		sda_o = 1'b0;
		#(2*Q) scl_o = 1'b1;
		#(2*Q) sda_o = 1'b1;
		#(2*Q);
	endtask : stop
	task automatic bit_xfer(input logic b, output logic s);
		sda_o = b;
		#Q scl_o = 1'b1;
		#Q s = sda_i;
		#Q scl_o = 1'b0;
		#Q;
	endtask : bit_xfer
	task automatic xfer(input logic [7:0] d, input logic n9, output logic [7:0] q, output logic ak);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(d[i], s);
			q[i] = s;
		end
		bit_xfer(n9, s);
		ak = ~s;
	endtask : xfer
endmodule : i2c_master_model

// ### i2c_regslave_tb.sv
// Self-checking bench for the register access I2C slave
`timescale 1ns/1ps
module i2c_regslave_tb;
	import i2c_rs_pkg::*;
	logic         clk_sys_i, rst_n_i, scl, sda_m, ak;
	logic         sda_o, sda_oe, soft_rst, busy, pwm_en, slow, prox;
	logic   [1:0] strap, lat;
	logic   [6:0] saddr;
	logic   [7:0] q;
	logic   [7:0] exp_q [256];
	power_state_t pwr;
	wire logic    sda_w;
	int           fail_count, n_compared, sr_cnt;
	integer       seed;
	// Open-drain data line with pull-up
	assign sda_w = sda_m & (~sda_oe | sda_o);
	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	// Soft reset pulses seen
	always @(posedge clk_sys_i) begin
		if (soft_rst === 1'b1) sr_cnt++;
	end
	i2c_regslave i2c_regslave_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_w),
		.strap_i(strap), .power_state_i(pwr), .sda_o(sda_o), .sda_oe_o(sda_oe), .soft_reset_o(soft_rst),
		.slave_addr_o(saddr), .busy_o(busy), .pwm_en_o(pwm_en), .sense_slow_o(slow), .prox_en_o(prox));
	i2c_master_model i2c_master_model_i (.sda_i(sda_w), .scl_o(scl), .sda_o(sda_m));
	function automatic logic [6:0] own_addr(input logic [1:0] s);
		return {5'h16, s};
	endfunction : own_addr
	task automatic chk_bit(input string n, input logic e, input logic g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s: expected %b seen %b", n, e, g);
		end
	endtask : chk_bit
	task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask : chk_byte
	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_of_test
	task automatic wb(input logic [7:0] d, input logic ea);
		i2c_master_model_i.xfer(d, 1'b1, q, ak);
		chk_bit("ack", ea, ak);
	endtask : wb
	// Stop, then busy must drop within a bounded wait
	task automatic stp;
		int n;
		i2c_master_model_i.stop;
		n = 0;
		while (busy !== 1'b0 && n < 20) begin
			#10 n++;
		end
		chk_bit("busy after stop", 1'b0, busy);
		if (n == 20) end_of_test;
	endtask : stp
	// Start, address (7 or 10 bit) with write, then pointer
	task automatic hdr(input logic ten, input logic [7:0] p);
		i2c_master_model_i.start;
		if (ten) begin
			wb(8'hf0, 1'b1);
			wb({1'b0, own_addr(lat)}, 1'b1);
		end else begin
			wb({own_addr(lat), 1'b0}, 1'b1);
		end
		wb(p, 1'b1);
	endtask : hdr
	task automatic wr_seq(input logic ten, input logic [7:0] p, input int n);
		logic [7:0] d;
		hdr(ten, p);
		for (int i = 0; i < n; i++) begin
			d = $random(seed);
			exp_q[p] = d;
			wb(d, 1'b1);
			p++;
		end
		stp;
	endtask : wr_seq
	// Pointer write, repeated start, sequential read, nack on last
	task automatic rd_seq(input logic ten, input logic [7:0] p, input int n);
		hdr(ten, p);
		i2c_master_model_i.start;
		wb(ten ? 8'hf1 : {own_addr(lat), 1'b1}, 1'b1);
		for (int i = 0; i < n; i++) begin
			i2c_master_model_i.xfer(8'hff, i == n - 1, q, ak);
			chk_byte("read data", exp_q[p], q);
			p++;
		end
		stp;
	endtask : rd_seq
	task automatic gc(input logic [7:0] c, input logic ea);
		i2c_master_model_i.start;
		wb(GC_ADDR_BYTE, 1'b1);
		wb(c, ea);
		stp;
		// Gap before the next transaction
		#2000;
	endtask : gc
	initial begin
		#900000;
		fail_count++;
		end_of_test;
	end
	initial begin
		logic [7:0] p;
		int         n;
		seed = 32'h6fce;
		rst_n_i = 1'b0;
		strap = 2'b01;
		pwr = PWR_ACTIVE;
		foreach (exp_q[i]) exp_q[i] = 8'h00;
		repeat (6) @(posedge clk_sys_i);
		#1 rst_n_i = 1'b1;
		#200;
		lat = strap;
		chk_byte("own address", {1'b0, own_addr(lat)}, {1'b0, saddr});
		for (int i = 0; i < 3; i++) begin
			pwr = power_state_t'(i);
			#20;
			chk_bit("pwm enable", pwr != PWR_HIBERNATE, pwm_en);
			chk_bit("slow sensing", pwr == PWR_SLEEP, slow);
			chk_bit("proximity", pwr == PWR_ACTIVE, prox);
		end
		// Foreign address, then own address without a start
		i2c_master_model_i.start;
		wb({own_addr(lat ^ 2'b10), 1'b0}, 1'b0);
		wb({own_addr(lat), 1'b0}, 1'b0);
		stp;
		// Sequential write and read across the top of the space
		wr_seq(1'b0, 8'hfe, 4);
		rd_seq(1'b0, 8'hfd, 5);
		for (int k = 0; k < 4; k++) begin
			pwr = power_state_t'($unsigned($random(seed)) % 3);
			p = $random(seed);
			n = 1 + $unsigned($random(seed)) % 4;
			wr_seq(k[0], p, n);
			rd_seq(k[1], p, n);
		end
		// Straps change but are held until a latch command
		strap = 2'b10;
		gc(8'h00, 1'b0);
		chk_byte("own address", {1'b0, own_addr(lat)}, {1'b0, saddr});
		gc(GC_LATCH_ONLY, 1'b1);
		lat = strap;
		chk_byte("own address", {1'b0, own_addr(lat)}, {1'b0, saddr});
		rd_seq(1'b0, 8'hfe, 2);
		strap = 2'b11;
		gc(GC_RESET_LATCH, 1'b1);
		lat = strap;
		foreach (exp_q[i]) exp_q[i] = 8'h00;
		chk_byte("soft resets", 8'h01, sr_cnt[7:0]);
		chk_byte("own address", {1'b0, own_addr(lat)}, {1'b0, saddr});
		rd_seq(1'b1, 8'hfe, 3);
		end_of_test;
	end
endmodule : i2c_regslave_tb
